/* bcs_sequencer.sv */
// The address map and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
`include "bcs_map.svh"

// Function
// - Bus cycles take T1, T2, T3; internal cycles take one state.
// - States advance once per two crystal clocks.
// - Wait states sit between T2 and T3, one state each.
// - Fetch strobe low during instruction fetch cycles.
// - Fetch drives translated 20-bit address from second half of T1.
// - Memory request and read go low in second half of T1.
// - Fetch data captured at start of T3; memory must be ready.
// - Combined wait sampled mid T2 and mid each wait state.
// - Data reads keep fetch strobe high, capture at T3 midpoint.
// - Write: request T1 late, data end T1, write at T2, release T3.
// - I/O uses io request, untranslated 16-bit address, upper lines low.
// - External I/O cycles get at least one automatic wait state.
// - Reset low six cycles aborts and restarts at address zero.
// - Bus request low leads to grant low after bus release.
// - Bus handed over only at machine cycle boundaries.
// - While granted, address, data and strobes float.
// - Bus request sampled before T3, T1 and each release state.
// - Wait is OR of external input and internal generator.
// - No refresh while a cycle is stretched by waits.
// - Wait control: bits 5:4 I/O count, bits 7:6 memory count.
// - Wait count is the larger of external and generated counts.
// - Memory accesses get zero to three programmed wait states.
// - Reset sets both wait fields to all ones.
// - Wait input ignored in reset; reset aborts stretched cycle.
module bcs_sequencer
  import bcs_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        reset_in_n,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic        op_valid,
  input  wire logic [2:0]  op_kind,
  input  wire logic [19:0] op_addr,
  input  wire logic [7:0]  op_wdata,
  output logic             op_ready,
  output logic             op_done,
  output logic      [7:0]  op_rdata,
  output logic             restart,
  input  wire logic        wait_in_n,
  input  wire logic        bus_request_in_n,
  output logic             bus_grant_out_n,
  output logic      [19:0] addr_out,
  output logic             addr_oe_n,
  output logic      [7:0]  data_out,
  output logic             data_oe_n,
  input  wire logic [7:0]  data_in,
  output logic             memory_request_n,
  output logic             io_request_n,
  output logic             read_n,
  output logic             write_n,
  output logic             ctrl_oe_n,
  output logic             fetch_cycle_strobe_n,
  output logic             refresh_allowed
);

  bcs_state_e  state_reg;
  bcs_state_e  state_next;
  bcs_op_e     op_reg;
  logic [19:0] addr_reg;
  logic [7:0]  wdata_reg;
  logic [7:0]  rdata_reg;
  logic [7:0]  wait_ctrl_reg;
  logic [2:0]  rst_cnt_reg;
  logic        phase;
  logic        bus_request_in_n_smp_reg;
  logic        wait_smp_reg;
  logic        gen_wait;
  logic        is_io;
  logic        is_int_io;
  logic        bus_cycle;
  logic        boundary;
  logic        step;

  // ----------------------------------------
  // State timing
  // ----------------------------------------
  bcs_clock_divider u_div (
    .clk_sys           (clk_sys),
    .rst               (rst),
    .phase_second_half (phase)
  );

  // A state ends at the second half; all moves except the restart jump to reset happen then
  assign step = phase;

  assign is_io     = (op_reg == BCS_OP_IO_READ) || (op_reg == BCS_OP_IO_WRITE);
  assign is_int_io = is_io && (addr_reg[15:0] <= `BCS_INT_IO_TOP);
  assign bus_cycle = (op_reg != BCS_OP_INTERNAL);

  bcs_wait_gen u_wait (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .load      (step && state_reg == BCS_ST_T1),
    .mem_count (wait_ctrl_reg[`BCS_MEM_WAIT_HI:`BCS_MEM_WAIT_LO]),
    .io_count  (wait_ctrl_reg[`BCS_IO_WAIT_HI:`BCS_IO_WAIT_LO]),
    .is_io     (is_io),
    .is_int_io (is_int_io),
    .step      (step && (state_reg == BCS_ST_T2 ||
                         state_reg == BCS_ST_TW)),
    .gen_wait  (gen_wait)
  );

  // ----------------------------------------
  // Reset restart
  // ----------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rst_cnt_reg <= 3'h0;
    end else if (reset_in_n) begin
      rst_cnt_reg <= 3'h0;
    end else if (rst_cnt_reg != `BCS_RESET_CYCLES) begin
      rst_cnt_reg <= rst_cnt_reg + 3'h1;
    end
  end

  assign restart = (rst_cnt_reg == `BCS_RESET_CYCLES);

  // ----------------------------------------
  // Wait and request sampling
  // ----------------------------------------
  // Sampled in first half, i.e. the falling edge of the system state
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wait_smp_reg   <= 1'b0;
      bus_request_in_n_smp_reg <= 1'b0;
    end else if (!phase) begin
      if (state_reg == BCS_ST_T2 || state_reg == BCS_ST_TW) begin
        wait_smp_reg <= !wait_in_n || gen_wait;
      end
      bus_request_in_n_smp_reg <= !bus_request_in_n;
    end
  end

  // ----------------------------------------
  // State machine
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      BCS_ST_RESET: begin
        state_next = BCS_ST_IDLE;
      end
      BCS_ST_IDLE, BCS_ST_T3: begin
        if (bus_request_in_n_smp_reg) begin
          state_next = BCS_ST_TX;
        end else if (op_valid) begin
          state_next = BCS_ST_T1;
        end else begin
          state_next = BCS_ST_IDLE;
        end
      end
      BCS_ST_T1: begin
        // Internal operation is a one-state machine cycle
        state_next = bus_cycle ? BCS_ST_T2 : BCS_ST_IDLE;
      end
      BCS_ST_T2, BCS_ST_TW: begin
        state_next = wait_smp_reg ? BCS_ST_TW : BCS_ST_T3;
      end
      BCS_ST_TX: begin
        state_next = bus_request_in_n_smp_reg ? BCS_ST_TX : BCS_ST_IDLE;
      end
      default: begin
        state_next = BCS_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_reg <= BCS_ST_RESET;
    end else if (restart) begin
      state_reg <= BCS_ST_RESET;
    end else if (step) begin
      state_reg <= state_next;
    end
  end

  // Idle and T3 in second half are the handover points
  assign boundary = step && (state_reg == BCS_ST_IDLE ||
                             state_reg == BCS_ST_T3);
  assign op_ready = boundary && !bus_request_in_n_smp_reg && !restart;

  // ----------------------------------------
  // Operation capture
  // ----------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      op_reg    <= BCS_OP_INTERNAL;
      addr_reg  <= 20'h00000;
      wdata_reg <= 8'h00;
    end else if (restart) begin
      op_reg    <= BCS_OP_INTERNAL;
      addr_reg  <= 20'h00000;
    end else if (op_ready && op_valid) begin
      op_reg    <= bcs_op_e'(op_kind);
      wdata_reg <= op_wdata;
      if (op_kind == BCS_OP_IO_READ || op_kind == BCS_OP_IO_WRITE) begin
        addr_reg <= {4'h0, op_addr[15:0]};
      end else begin
        addr_reg <= op_addr;
      end
    end
  end

  // ----------------------------------------
  // Read data capture
  // ----------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdata_reg <= 8'h00;
    end else if (step && state_next == BCS_ST_T3 &&
                 (state_reg == BCS_ST_T2 || state_reg == BCS_ST_TW)) begin
      // Fetch latches on the edge that opens T3
      if (op_reg == BCS_OP_FETCH) begin
        rdata_reg <= data_in;
      end
    end else if (state_reg == BCS_ST_T3 && !phase) begin
      // Data reads latch mid T3, before the read strobe drops
      if (op_reg == BCS_OP_MEM_READ || op_reg == BCS_OP_IO_READ) begin
        rdata_reg <= data_in;
      end
    end
  end

  assign op_rdata = rdata_reg;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      op_done <= 1'b0;
    end else begin
      op_done <= step && !restart && (state_reg == BCS_ST_T3 ||
                 (state_reg == BCS_ST_T1 && !bus_cycle));
    end
  end

  // ----------------------------------------
  // Bus pins
  // ----------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      memory_request_n     <= 1'b1;
      io_request_n         <= 1'b1;
      read_n               <= 1'b1;
      write_n              <= 1'b1;
      fetch_cycle_strobe_n <= 1'b1;
      data_oe_n            <= 1'b1;
      addr_out             <= 20'h00000;
      data_out             <= 8'h00;
    end else begin
      addr_out <= addr_reg;
      data_out <= wdata_reg;
      if (restart || !bus_cycle || state_reg == BCS_ST_TX ||
          state_reg == BCS_ST_IDLE || state_reg == BCS_ST_RESET) begin
        memory_request_n     <= 1'b1;
        io_request_n         <= 1'b1;
        read_n               <= 1'b1;
        write_n              <= 1'b1;
        fetch_cycle_strobe_n <= 1'b1;
        data_oe_n            <= 1'b1;
      end else begin
        fetch_cycle_strobe_n <= (op_reg != BCS_OP_FETCH);
        if (state_reg == BCS_ST_T1 && !phase) begin
          // Strobes go active for the second half of T1
          memory_request_n <= is_io;
          io_request_n     <= !is_io;
          read_n <= (op_reg == BCS_OP_MEM_WRITE || op_reg == BCS_OP_IO_WRITE);
        end else if (state_reg == BCS_ST_T1 && phase) begin
          // Write data from the end of T1, write strobe from T2
          data_oe_n <= !(op_reg == BCS_OP_MEM_WRITE ||
                         op_reg == BCS_OP_IO_WRITE);
          write_n <= !(op_reg == BCS_OP_MEM_WRITE ||
                       op_reg == BCS_OP_IO_WRITE);
        end else if (state_reg == BCS_ST_T3 && !phase) begin
          // Strobes drop in the second half of T3, data one clock later
          memory_request_n <= 1'b1;
          io_request_n     <= 1'b1;
          read_n           <= 1'b1;
          write_n          <= 1'b1;
        end else if (state_reg == BCS_ST_T3 && phase) begin
          data_oe_n            <= 1'b1;
          fetch_cycle_strobe_n <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------
  // Bus release
  // ----------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      bus_grant_out_n <= 1'b1;
    end else begin
      bus_grant_out_n <= !(state_reg == BCS_ST_TX) || restart;
    end
  end

  // Floats only while granted; held level otherwise
  assign addr_oe_n = !bus_grant_out_n;
  assign ctrl_oe_n = !bus_grant_out_n;

  // Refresh must wait for the stretched cycle and a held bus
  assign refresh_allowed = (state_reg != BCS_ST_TW) &&
                           bus_grant_out_n;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wait_ctrl_reg <= `BCS_WAIT_CTRL_RST;
    end else if (restart) begin
      wait_ctrl_reg <= `BCS_WAIT_CTRL_RST;
    end else if (reg_wr && reg_addr == `BCS_OFF_WAIT_CTRL) begin
      wait_ctrl_reg <= reg_wdata;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      if (reg_addr == `BCS_OFF_WAIT_CTRL) begin
        reg_rdata <= wait_ctrl_reg;
      end else if (reg_addr == `BCS_OFF_STATUS) begin
        reg_rdata <= {3'h0, !bus_grant_out_n, restart, 3'(state_reg)};
      end else if (reg_addr == `BCS_OFF_PC_LO) begin
        reg_rdata <= addr_reg[7:0];
      end else if (reg_addr == `BCS_OFF_PC_HI) begin
        reg_rdata <= addr_reg[15:8];
      end else if (reg_addr == `BCS_OFF_PC_UP) begin
        reg_rdata <= {4'h0, addr_reg[19:16]};
      end else begin
        reg_rdata <= 8'h00;
      end
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule

/* bcs_map.svh */
`ifndef BCS_MAP_SVH
`define BCS_MAP_SVH

// ----------------------------------------
// Register map
// ----------------------------------------
`define BCS_ADDR_W          4
`define BCS_OFF_WAIT_CTRL   4'h0
`define BCS_OFF_STATUS      4'h1
`define BCS_OFF_PC_LO       4'h2
`define BCS_OFF_PC_HI       4'h3
`define BCS_OFF_PC_UP       4'h4

// ----------------------------------------
// Wait control fields
// ----------------------------------------
`define BCS_IO_WAIT_LO      4
`define BCS_IO_WAIT_HI      5
`define BCS_MEM_WAIT_LO     6
`define BCS_MEM_WAIT_HI     7
`define BCS_WAIT_CTRL_RST   8'hf0

// ----------------------------------------
// Timing
// ----------------------------------------
`define BCS_RESET_CYCLES    3'h6
`define BCS_IO_MIN_WAIT     3'h1
`define BCS_INT_IO_TOP      16'h003f

`endif

/* bcs_pkg.sv */
package bcs_pkg;

  typedef enum logic [2:0] {
    BCS_OP_INTERNAL,
    BCS_OP_FETCH,
    BCS_OP_MEM_READ,
    BCS_OP_MEM_WRITE,
    BCS_OP_IO_READ,
    BCS_OP_IO_WRITE
  } bcs_op_e;

  typedef enum logic [2:0] {
    BCS_ST_IDLE,
    BCS_ST_T1,
    BCS_ST_T2,
    BCS_ST_TW,
    BCS_ST_T3,
    BCS_ST_TX,
    BCS_ST_RESET
  } bcs_state_e;

endpackage

/* bcs_clock_divider.sv */
`timescale 1ns/1ps
`include "bcs_map.svh"

module bcs_clock_divider
  import bcs_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic rst,
  output logic      phase_second_half
);

  // ----------------------------------------
  // Crystal divide by two
  // ----------------------------------------
  // The crystal-rate clk_sys toggles the phase; one system state is two
  // crystal cycles, first half then second half.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      phase_second_half <= 1'b0;
    end else begin
      phase_second_half <= ~phase_second_half;
    end
  end

endmodule

/* bcs_wait_gen.sv */
`timescale 1ns/1ps
`include "bcs_map.svh"

module bcs_wait_gen
  import bcs_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       load,
  input  wire logic [1:0] mem_count,
  input  wire logic [1:0] io_count,
  input  wire logic       is_io,
  input  wire logic       is_int_io,
  input  wire logic       step,
  output logic            gen_wait
);

  logic [2:0] remain_reg;
  logic [2:0] remain_next;

  // ----------------------------------------
  // Programmed wait count
  // ----------------------------------------
  always_comb begin
    if (!is_io) begin
      remain_next = {1'b0, mem_count};
    end else if (is_int_io) begin
      remain_next = 3'h0;
    end else begin
      remain_next = {1'b0, io_count} + `BCS_IO_MIN_WAIT;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      remain_reg <= 3'h0;
    end else if (load) begin
      remain_reg <= remain_next;
    end else if (step && remain_reg != 3'h0) begin
      remain_reg <= remain_reg - 3'h1;
    end
  end

  // Max of both sources falls out of ORing per state
  assign gen_wait = (remain_reg != 3'h0);

endmodule

/* bcs_sequencer_monitor.sv */
`timescale 1ns/1ps
module bcs_sequencer_monitor
  import bcs_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        reset_in_n,
  input wire logic        op_valid,
  input wire logic        op_ready,
  input wire logic [2:0]  op_kind,
  input wire logic        restart,
  input wire logic        bus_request_in_n,
  input wire logic        bus_grant_out_n,
  input wire logic [19:0] addr_out,
  input wire logic        addr_oe_n,
  input wire logic        data_oe_n,
  input wire logic        ctrl_oe_n,
  input wire logic        memory_request_n,
  input wire logic        io_request_n,
  input wire logic        read_n,
  input wire logic        write_n,
  input wire logic        fetch_cycle_strobe_n,
  input wire logic        refresh_allowed
);
  // ----------------------------------------
  // Sequences
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_held_low;
    (!reset_in_n) [*8];
  endsequence
  sequence s_take_int;
    op_valid && op_ready && op_kind == BCS_OP_INTERNAL;
  endsequence
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  AST_FLOAT: assert property (
    !bus_grant_out_n |-> addr_oe_n && data_oe_n && ctrl_oe_n)
    else $error("bus driven while granted");
  AST_GRANT_REQ: assert property (
    $fell(bus_grant_out_n) |-> $past(!bus_request_in_n))
    else $error("grant without request");
  AST_GRANT_EDGE: assert property (
    $fell(bus_grant_out_n) |-> $past(memory_request_n && io_request_n))
    else $error("grant inside a bus cycle");
  AST_IO_ADDR: assert property (
    !io_request_n |-> addr_out[19:16] == 4'h0 && memory_request_n)
    else $error("bad io cycle address or strobe");
  AST_WR_DATA: assert property (
    !write_n |-> !data_oe_n && read_n)
    else $error("write strobe without data");
  AST_FETCH: assert property (
    !fetch_cycle_strobe_n |-> io_request_n && write_n)
    else $error("fetch strobe outside a fetch");
  AST_HOLD: assert property (
    !memory_request_n && $past(!memory_request_n) |-> $stable(addr_out))
    else $error("address moved inside a cycle");
  AST_NO_REFRESH: assert property (
    !refresh_allowed |-> !bus_grant_out_n || !memory_request_n
      || !io_request_n)
    else $error("refresh blocked with bus idle");
  AST_RESTART: assert property (
    s_held_low |-> restart)
    else $error("no restart after long reset");
  AST_INT_IDLE: assert property (
    s_take_int |-> ##1 (memory_request_n && io_request_n) [*2])
    else $error("strobe in internal cycle");
endmodule

bind bcs_sequencer bcs_sequencer_monitor bcs_sequencer_monitor_i (.*);

/* bcs_bus_model.sv */
`timescale 1ns/1ps
module bcs_bus_model (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic [19:0] addr_out,
  input  wire logic        memory_request_n,
  input  wire logic        io_request_n,
  input  wire logic        read_n,
  input  wire logic        write_n,
  input  wire logic [7:0]  data_out,
  input  wire logic        data_oe_n,
  input  wire logic [1:0]  ext_w,
  output logic             wait_in_n,
  output logic      [7:0]  data_in,
  output logic      [7:0]  wr_data
);
  // ----------------------------------------
  // Memory and peripheral side
  // ----------------------------------------
  logic [3:0] run_reg;
  logic [7:0] last_reg;
  wire act = !memory_request_n || !io_request_n;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      run_reg  <= 4'h0;
      last_reg <= 8'h00;
      wr_data  <= 8'h00;
    end else begin
      run_reg  <= act ? run_reg + 4'h1 : 4'h0;
      last_reg <= data_in;
      if (!write_n && !data_oe_n)
        wr_data <= data_out;
    end
  end
  // Slow device: ext_w states; 3 stalls until the cycle is aborted
  assign wait_in_n = !(act && (ext_w == 2'h3 ||
                     run_reg < {1'b0, ext_w, 1'b0}));
  // Released bus toggles so stale data never looks valid
  assign data_in = !read_n ? addr_out[7:0] ^ 8'h5a : ~last_reg;
endmodule

/* cpu_bus_cycle_sequencer_bench.sv */
`timescale 1ns/1ps
`include "bcs_map.svh"
module cpu_bus_cycle_sequencer_bench
  import bcs_pkg::*;
();
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic        reset_in_n = 1'b1;
  logic [3:0]  reg_addr = 4'h0;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        op_valid = 1'b0;
  logic [2:0]  op_kind = 3'h0;
  logic [19:0] op_addr = 20'h00000;
  logic [7:0]  op_wdata = 8'h00;
  logic        bus_request_in_n = 1'b1;
  logic [1:0]  ext_w = 2'h0;
  logic [7:0]  reg_rdata, op_rdata, data_out, data_in, wr_data;
  logic [19:0] addr_out;
  logic        op_ready, op_done, restart, wait_in_n, bus_grant_out_n;
  logic        addr_oe_n, data_oe_n, ctrl_oe_n, memory_request_n;
  logic        io_request_n, read_n, write_n, fetch_cycle_strobe_n;
  logic        refresh_allowed;
  int          err_total = 0;
  int          n_tests = 0;

  always #25 clk_sys = ~clk_sys;
  bcs_sequencer bcs_sequencer_i (.*);
  bcs_bus_model bcs_bus_model_i (.*);

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checks=%0d errors=%0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic bail(input logic ok);
    if (!ok) begin
      err_total++;
      report_and_stop;
    end
  endtask
  task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask
  task automatic check_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    @(negedge clk_sys);
    check(reg_rdata, d);
  endtask
  task automatic take_op(input bcs_op_e k, input logic [19:0] a);
    logic ok;
    ok = 1'b0;
    @(posedge clk_sys);
    op_kind  <= k;
    op_addr  <= a;
    op_wdata <= a[7:0] ^ 8'hc3;
    op_valid <= 1'b1;
    for (int i = 0; i < 40 && !ok; i++) begin
      @(negedge clk_sys);
      ok = (op_ready === 1'b1);
    end
    bail(ok);
    @(posedge clk_sys);
    op_valid <= 1'b0;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic run_op(input bcs_op_e k, input logic [19:0] a,
                        input logic [7:0] wc, input logic [1:0] ew);
    int          sn, fs, w;
    logic        dn, io;
    logic [19:0] ioa;
    sn = 0;
    fs = 0;
    dn = 1'b0;
    ioa = 20'h0;
    io = (k == BCS_OP_IO_READ || k == BCS_OP_IO_WRITE);
    // Low I/O page is on-chip and skips the automatic wait
    w = io ? ((a[15:0] <= `BCS_INT_IO_TOP) ? 0 : wc[5:4] + 1) : wc[7:6];
    if (ew > w) w = ew;
    reg_write(`BCS_OFF_WAIT_CTRL, wc);
    ext_w <= ew;
    take_op(k, a);
    for (int i = 0; i < 60 && !dn; i++) begin
      @(negedge clk_sys);
      if (!memory_request_n || !io_request_n) sn++;
      if (!fetch_cycle_strobe_n) fs++;
      if (!io_request_n) ioa = addr_out;
      dn = (op_done === 1'b1);
    end
    bail(dn);
    check(sn, (k == BCS_OP_INTERNAL) ? 0 : 4 + 2 * w);
    check(fs != 0, k == BCS_OP_FETCH);
    if (io)
      check(ioa, {4'h0, a[15:0]});
    if (k == BCS_OP_FETCH || k == BCS_OP_MEM_READ || k == BCS_OP_IO_READ)
      check(op_rdata, a[7:0] ^ 8'h5a);
    if (k == BCS_OP_MEM_WRITE || k == BCS_OP_IO_WRITE)
      check(wr_data, a[7:0] ^ 8'hc3);
  endtask
  task automatic t_grant;
    @(posedge clk_sys);
    bus_request_in_n <= 1'b0;
    for (int i = 0; i < 30 && bus_grant_out_n !== 1'b0; i++)
      @(negedge clk_sys);
    bail(bus_grant_out_n === 1'b0);
    check(bus_grant_out_n, 1'b0);
    check({addr_oe_n, data_oe_n, ctrl_oe_n, refresh_allowed}, 4'he);
    repeat (8) @(negedge clk_sys);
    check(bus_grant_out_n, 1'b0);
    @(posedge clk_sys);
    bus_request_in_n <= 1'b1;
    for (int i = 0; i < 30 && bus_grant_out_n !== 1'b1; i++)
      @(negedge clk_sys);
    bail(bus_grant_out_n === 1'b1);
    check(bus_grant_out_n, 1'b1);
  endtask
  task automatic t_restart;
    reg_write(`BCS_OFF_WAIT_CTRL, 8'h00);
    ext_w <= 2'h3;
    take_op(BCS_OP_MEM_READ, 20'h00400);
    repeat (5) @(negedge clk_sys);
    check(refresh_allowed, 1'b0);
    @(posedge clk_sys);
    reset_in_n <= 1'b0;
    repeat (8) @(posedge clk_sys);
    @(negedge clk_sys);
    check(restart, 1'b1);
    check(memory_request_n, 1'b1);
    @(posedge clk_sys);
    reset_in_n <= 1'b1;
    ext_w <= 2'h0;
    repeat (6) @(posedge clk_sys);
    check_reg(`BCS_OFF_WAIT_CTRL, 8'hf0);
    check_reg(`BCS_OFF_PC_LO, 8'h00);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    check_reg(`BCS_OFF_WAIT_CTRL, 8'hf0);
    reg_write(`BCS_OFF_WAIT_CTRL, 8'h9c);
    check_reg(`BCS_OFF_WAIT_CTRL, 8'h9c);
    check_reg(4'hf, 8'h00);
    run_op(BCS_OP_FETCH, 20'h01234, 8'h00, 2'h0);
    run_op(BCS_OP_MEM_READ, 20'h0abcd, 8'h40, 2'h0);
    run_op(BCS_OP_MEM_WRITE, 20'h0beef, 8'hc0, 2'h0);
    run_op(BCS_OP_MEM_READ, 20'h00010, 8'h80, 2'h1);
    run_op(BCS_OP_FETCH, 20'h00020, 8'h00, 2'h2);
    run_op(BCS_OP_IO_READ, 20'hf1234, 8'h00, 2'h0);
    run_op(BCS_OP_IO_WRITE, 20'h05678, 8'h30, 2'h0);
    run_op(BCS_OP_IO_READ, 20'h00020, 8'h30, 2'h0);
    run_op(BCS_OP_INTERNAL, 20'h00000, 8'h00, 2'h0);
    t_grant;
    t_restart;
    run_op(BCS_OP_FETCH, 20'h00000, 8'h00, 2'h0);
    report_and_stop;
  end
endmodule
